// ===== hw/hot_plug_slot_sense.sv
// Summary of operation
// - the slot 2 clock switch enable output gates the PCI clock into the second slot.
// - each slot's 66 MHz capable input decides whether its card can run conventional PCI at 66 MHz.
// - a latch sensor input is active low and low means the retention latch is closed.
// - the capability-present input high means the slot's tri-state pin is not grounded, so PCI-X works.
// - the speed class input low means PCI-X 66 MHz only and high means 133 MHz capable.
// - after reset the secondary bus runs conventional PCI at 33 MHz until the slots are examined.
// - firmware scans all slots and, when all cards and the system agree, resets the bus into PCI-X mode.
// - slot 2 clock enable, 66 MHz and latch inputs are used only in two-slot parallel mode.
// - slot 1 latch and capability inputs are used in no-glue, one-slot and two-slot parallel modes.
// - config pins 1111 select no-glue, 1001 one-slot parallel and 1010 two-slot parallel mode.

`timescale 1ns/1ps
`include "slot_sense_cfg.svh"

module hot_plug_slot_sense (
  input  wire logic                        MCLK_I,
  input  wire logic                        RST_N_I,
  input  wire logic [`SLOT_CFG_WIDTH-1:0]  HOTPLUG_SLOT_CONFIG_PINS_I,
  input  wire logic                        SLOT1_SPEED66_CAPABLE_I,
  input  wire logic                        SLOT2_SPEED66_CAPABLE_I,
  input  wire logic                        SLOT1_RETENTION_LATCH_N_I,
  input  wire logic                        SLOT2_RETENTION_LATCH_N_I,
  input  wire logic                        SLOT1_PCIX_CAP_PRESENT_I,
  input  wire logic                        SLOT1_PCIX_SPEED_CLASS_I,
  input  wire logic                        SLOT2_PCIX_CAP_PRESENT_I,
  input  wire logic                        SLOT2_PCIX_SPEED_CLASS_I,
  input  wire logic                        SLOT2_CLOCK_REQ_I,
  input  wire logic                        SCAN_START_I,
  input  wire logic                        SYSTEM_PCIX_OK_I,
  input  wire logic                        SYSTEM_133_OK_I,
  output logic                             SLOT2_CLOCK_SWITCH_ENABLE_O,
  output logic                             HOTPLUG_ENABLED_O,
  output logic [1:0]                       SLOT_COUNT_O,
  output logic [1:0]                       SLOT_LATCH_CLOSED_O,
  output logic [1:0]                       SLOT_SPEED66_O,
  output logic [1:0]                       SLOT_PCIX_O,
  output logic [1:0]                       SLOT_PCIX133_O,
  output logic [1:0]                       LATCH_CHANGE_O,
  output logic [`BUS_MODE_WIDTH-1:0]       BUS_MODE_O,
  output logic                             BUS_RESET_O
);

  // ----------------------------------------
  // input synchronisation
  // ----------------------------------------
  localparam int NSENSE = 12;

  logic [NSENSE-1:0] raw_in;
  logic [NSENSE-1:0] sync_in;

  assign raw_in = {HOTPLUG_SLOT_CONFIG_PINS_I,
                   SLOT2_PCIX_SPEED_CLASS_I, SLOT2_PCIX_CAP_PRESENT_I,
                   SLOT2_SPEED66_CAPABLE_I, SLOT2_RETENTION_LATCH_N_I,
                   SLOT1_PCIX_SPEED_CLASS_I, SLOT1_PCIX_CAP_PRESENT_I,
                   SLOT1_SPEED66_CAPABLE_I, SLOT1_RETENTION_LATCH_N_I};

  sense_sync #(
    .WIDTH  (NSENSE),
    .STAGES (`SYNC_STAGES)
  ) u_sync (
    .clk_i   (MCLK_I),
    .rst_n_i (RST_N_I),
    .async_i (raw_in),
    .sync_o  (sync_in)
  );

  // ----------------------------------------
  // configuration decode
  // ----------------------------------------
  wire [`SLOT_CFG_WIDTH-1:0]   cfg_pins = sync_in[11:8];
  slot_sense_pkg::slot_sense_type s1_raw;
  slot_sense_pkg::slot_sense_type s2_raw;
  slot_sense_pkg::cfg_mode_type   cfg_mode;

  assign s1_raw = slot_sense_pkg::slot_sense_type'({sync_in[0], sync_in[1], sync_in[2], sync_in[3]});
  assign s2_raw = slot_sense_pkg::slot_sense_type'({sync_in[4], sync_in[5], sync_in[6], sync_in[7]});

  assign cfg_mode = (cfg_pins == `SLOT_CFG_NO_GLUE) ? slot_sense_pkg::CFG_NO_GLUE :
                    (cfg_pins == `SLOT_CFG_ONE_PAR) ? slot_sense_pkg::CFG_ONE_PAR :
                    (cfg_pins == `SLOT_CFG_TWO_PAR) ? slot_sense_pkg::CFG_TWO_PAR :
                                                      slot_sense_pkg::CFG_NONE;

  wire slot1_used = (cfg_mode != slot_sense_pkg::CFG_NONE);
  wire slot2_used = (cfg_mode == slot_sense_pkg::CFG_TWO_PAR);

  // ----------------------------------------
  // per-slot status
  // ----------------------------------------
  slot_sense_pkg::slot_sense_type slot_raw [2];
  logic [1:0] slot_used;
  logic [1:0] latch_closed_d;
  logic [1:0] speed66_d;
  logic [1:0] pcix_d;
  logic [1:0] pcix133_d;
  logic [1:0] latch_closed_q;
  logic [1:0] speed66_q;
  logic [1:0] pcix_q;
  logic [1:0] pcix133_q;
  logic [1:0] latch_change_q;

  assign slot_raw[0] = s1_raw;
  assign slot_raw[1] = s2_raw;
  assign slot_used   = {slot2_used, slot1_used};

  generate
    for (genvar i = 0; i < 2; i++) begin : g_slot
      assign latch_closed_d[i] = slot_used[i] & ~slot_raw[i].latch_n;
      assign speed66_d[i]      = slot_used[i] & slot_raw[i].speed66;
      assign pcix_d[i]         = slot_used[i] & slot_raw[i].pcix_cap;
      assign pcix133_d[i]      = slot_used[i] & slot_raw[i].pcix_cap & slot_raw[i].pcix_class;
    end
  endgenerate

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      latch_closed_q <= 2'h0;
      speed66_q      <= 2'h0;
      pcix_q         <= 2'h0;
      pcix133_q      <= 2'h0;
      latch_change_q <= 2'h0;
    end else begin
      latch_closed_q <= latch_closed_d;
      speed66_q      <= speed66_d;
      pcix_q         <= pcix_d;
      pcix133_q      <= pcix133_d;
      latch_change_q <= latch_closed_d ^ latch_closed_q;
    end
  end

  // ----------------------------------------
  // slot 2 clock isolation switch
  // ----------------------------------------
  logic clk2_en_q;
  wire  clk2_en_d = slot2_used & SLOT2_CLOCK_REQ_I;

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      clk2_en_q <= 1'b0;
    end else begin
      clk2_en_q <= clk2_en_d;
    end
  end

  // ----------------------------------------
  // bus mode after scan
  // ----------------------------------------
  slot_sense_pkg::bus_state_type state_q;
  slot_sense_pkg::bus_state_type state_d;
  logic [`BUS_MODE_WIDTH-1:0]    mode_q;
  logic [`BUS_MODE_WIDTH-1:0]    mode_d;
  logic                          bus_reset_q;

  // a slot counts only when used and its retention latch is closed
  wire [1:0] occupied = latch_closed_q & slot_used;
  wire all_pcix   = &(pcix_q | ~occupied);
  wire all_133    = &(pcix133_q | ~occupied);
  wire all_66     = &(speed66_q | ~occupied);
  wire any_slot   = |occupied;

  wire [`BUS_MODE_WIDTH-1:0] scan_mode =
    !any_slot                           ? `BUS_MODE_PCI33 :
    (all_pcix && SYSTEM_PCIX_OK_I)      ? (all_133 && SYSTEM_133_OK_I ? `BUS_MODE_PCIX133 : `BUS_MODE_PCIX66) :
    all_66                              ? `BUS_MODE_PCI66 :
                                          `BUS_MODE_PCI33;

  always_comb begin
    state_d = state_q;
    mode_d  = mode_q;
    case (state_q)
      slot_sense_pkg::ST_CONV33: begin
        mode_d = `BUS_MODE_PCI33;
        if (SCAN_START_I) begin
          state_d = slot_sense_pkg::ST_SCAN;
        end
      end
      slot_sense_pkg::ST_SCAN: begin
        mode_d  = scan_mode;
        state_d = slot_sense_pkg::ST_RUN;
      end
      slot_sense_pkg::ST_RUN: begin
        if (SCAN_START_I) begin
          state_d = slot_sense_pkg::ST_SCAN;
        end
      end
      default: begin
        state_d = slot_sense_pkg::ST_CONV33;
        mode_d  = `BUS_MODE_PCI33;
      end
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      state_q     <= slot_sense_pkg::ST_CONV33;
      mode_q      <= `BUS_MODE_PCI33;
      bus_reset_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      mode_q      <= mode_d;
      bus_reset_q <= (state_q == slot_sense_pkg::ST_SCAN) && (mode_d != mode_q);
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign SLOT2_CLOCK_SWITCH_ENABLE_O = clk2_en_q;
  assign HOTPLUG_ENABLED_O           = slot1_used;
  assign SLOT_COUNT_O                = {1'b0, slot1_used} + {1'b0, slot2_used};
  assign SLOT_LATCH_CLOSED_O         = latch_closed_q;
  assign SLOT_SPEED66_O              = speed66_q;
  assign SLOT_PCIX_O                 = pcix_q;
  assign SLOT_PCIX133_O              = pcix133_q;
  assign LATCH_CHANGE_O              = latch_change_q;
  assign BUS_MODE_O                  = mode_q;
  assign BUS_RESET_O                 = bus_reset_q;

endmodule : hot_plug_slot_sense

// ===== hw/sense_sync.sv
`timescale 1ns/1ps
`include "slot_sense_cfg.svh"

module sense_sync #(
  parameter int WIDTH  = 4,
  parameter int STAGES = `SYNC_STAGES
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage_q [STAGES];

  // refuse a depth that cannot settle a level
  if (STAGES < 2 || WIDTH < 1) begin : g_bad_params
    $error("sense_sync: bad parameters");
  end

  generate
    for (genvar s = 0; s < STAGES; s++) begin : g_stage
      if (s == 0) begin : g_first
        always_ff @(posedge clk_i) begin
          if (!rst_n_i) begin
            stage_q[0] <= '0;
          end else begin
            stage_q[0] <= async_i;
          end
        end
      end else begin : g_next
        always_ff @(posedge clk_i) begin
          if (!rst_n_i) begin
            stage_q[s] <= '0;
          end else begin
            stage_q[s] <= stage_q[s-1];
          end
        end
      end
    end
  endgenerate

  assign sync_o = stage_q[STAGES-1];

endmodule : sense_sync

// ===== hw/slot_sense_cfg.svh
`ifndef SLOT_SENSE_CFG_SVH
`define SLOT_SENSE_CFG_SVH

// slot configuration pin codes
`define SLOT_CFG_WIDTH      4
`define SLOT_CFG_NO_GLUE    4'hF
`define SLOT_CFG_ONE_PAR    4'h9
`define SLOT_CFG_TWO_PAR    4'hA

// synchroniser depth
`define SYNC_STAGES         2

// bus mode codes
`define BUS_MODE_PCI33      3'h0
`define BUS_MODE_PCI66      3'h1
`define BUS_MODE_PCIX66     3'h2
`define BUS_MODE_PCIX133    3'h3
`define BUS_MODE_WIDTH      3

`endif

// ===== hw/slot_sense_pkg.sv
package slot_sense_pkg;

  typedef enum logic [3:0] {
    CFG_NONE    = 4'h1,
    CFG_NO_GLUE = 4'h2,
    CFG_ONE_PAR = 4'h4,
    CFG_TWO_PAR = 4'h8
  } cfg_mode_type;

  // raw sense bits of one slot
  typedef struct packed {
    logic latch_n;
    logic speed66;
    logic pcix_cap;
    logic pcix_class;
  } slot_sense_type;

  typedef enum logic [2:0] {
    ST_CONV33 = 3'h1,
    ST_SCAN   = 3'h2,
    ST_RUN    = 3'h4
  } bus_state_type;

endpackage : slot_sense_pkg

// ===== test/hot_plug_slot_sense_props.sv
`timescale 1ns/1ps
`include "slot_sense_cfg.svh"
module hot_plug_slot_sense_props (
  input wire logic                       MCLK_I, RST_N_I, SLOT2_CLOCK_REQ_I, SCAN_START_I,
  input wire logic [`SLOT_CFG_WIDTH-1:0] HOTPLUG_SLOT_CONFIG_PINS_I,
  input wire logic                       SLOT1_RETENTION_LATCH_N_I, SLOT2_SPEED66_CAPABLE_I,
  input wire logic                       SLOT1_PCIX_CAP_PRESENT_I, SLOT1_PCIX_SPEED_CLASS_I,
  input wire logic                       SLOT2_CLOCK_SWITCH_ENABLE_O, HOTPLUG_ENABLED_O, BUS_RESET_O,
  input wire logic [1:0]                 SLOT_COUNT_O, SLOT_LATCH_CLOSED_O, SLOT_SPEED66_O,
  input wire logic [1:0]                 SLOT_PCIX_O, SLOT_PCIX133_O, LATCH_CHANGE_O,
  input wire logic [`BUS_MODE_WIDTH-1:0] BUS_MODE_O
);
  // ----------------------------------------
  // settle tracking after reset
  // ----------------------------------------
  logic [2:0] up_q;
  logic [3:0] c1_q, c2_q;
  logic       hp_q, two_q;
  wire        ok  = up_q == 3'h7;
  wire [1:0]  cnt = (c2_q == 4'hA) ? 2'h2 : (c2_q == 4'hF || c2_q == 4'h9) ? 2'h1 : 2'h0;
  wire        u1  = ok && HOTPLUG_ENABLED_O && hp_q;
  wire        u2  = ok && SLOT_COUNT_O == 2'h2 && two_q;
  always_ff @(posedge MCLK_I) begin
    up_q  <= !RST_N_I ? 3'h0 : up_q + {2'h0, !ok};
    c1_q  <= HOTPLUG_SLOT_CONFIG_PINS_I;
    c2_q  <= c1_q;
    hp_q  <= HOTPLUG_ENABLED_O;
    two_q <= SLOT_COUNT_O == 2'h2;
  end
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence new_mode;
    $changed(BUS_MODE_O) ##0 BUS_RESET_O;
  endsequence
  a_count_decode: assert property (ok |-> SLOT_COUNT_O == cnt && HOTPLUG_ENABLED_O == (cnt != 2'h0))
    else $error("slot count decode wrong");
  a_latch_low: assert property (u1 |-> SLOT_LATCH_CLOSED_O[0] == !$past(SLOT1_RETENTION_LATCH_N_I, 3))
    else $error("latch polarity wrong");
  a_speed66_two: assert property (u2 |-> SLOT_SPEED66_O[1] == $past(SLOT2_SPEED66_CAPABLE_I, 3))
    else $error("slot 2 speed flag wrong");
  a_pcix_one: assert property (u1 |-> SLOT_PCIX_O[0] == $past(SLOT1_PCIX_CAP_PRESENT_I, 3))
    else $error("slot 1 pcix flag wrong");
  a_class_one: assert property (u1 && SLOT_PCIX_O[0] |-> SLOT_PCIX133_O[0] == $past(SLOT1_PCIX_SPEED_CLASS_I, 3))
    else $error("slot 1 speed class wrong");
  a_slot2_unused: assert property (ok && SLOT_COUNT_O != 2'h2 && !two_q |-> !SLOT2_CLOCK_SWITCH_ENABLE_O
    && SLOT_LATCH_CLOSED_O[1] == 1'b0 && SLOT_SPEED66_O[1] == 1'b0 && SLOT_PCIX_O[1] == 1'b0)
    else $error("slot 2 used outside two slot mode");
  a_slot1_unused: assert property (ok && !HOTPLUG_ENABLED_O && !hp_q |-> SLOT_LATCH_CLOSED_O[0] == 1'b0
    && SLOT_SPEED66_O[0] == 1'b0 && SLOT_PCIX_O[0] == 1'b0)
    else $error("slot 1 used with hot plug off");
  a_clock_switch: assert property ((u2 && SLOT2_CLOCK_REQ_I) [*3] |-> SLOT2_CLOCK_SWITCH_ENABLE_O)
    else $error("slot 2 clock switch not closed");
  a_mode_hold: assert property (ok && $changed(BUS_MODE_O) |-> $past(SCAN_START_I, 2))
    else $error("bus mode moved without scan");
  a_reset_pulse: assert property (ok && BUS_RESET_O |-> new_mode ##1 !BUS_RESET_O)
    else $error("bus reset pulse wrong");
  a_latch_pulse: assert property (ok |-> LATCH_CHANGE_O == (SLOT_LATCH_CLOSED_O ^ $past(SLOT_LATCH_CLOSED_O)))
    else $error("latch change pulse wrong");
endmodule : hot_plug_slot_sense_props
bind hot_plug_slot_sense hot_plug_slot_sense_props u_hot_plug_slot_sense_props (.*);

// ===== test/slot_model.sv
`timescale 1ns/1ps
module slot_model (
  input  wire logic                           clk_i,
  input  wire logic                           sensor_i,
  input  wire slot_sense_pkg::slot_sense_type card_i,
  output slot_sense_pkg::slot_sense_type      pins_o
);
  always_ff @(posedge clk_i) begin
    pins_o <= card_i & {sensor_i, 3'h7}; // no sensor fitted ties latch low
  end
endmodule : slot_model

// ===== test/test_hot_plug_slot_sense.sv
`timescale 1ns/1ps
module test_hot_plug_slot_sense;
  logic clk = 0, rst_n = 0, req = 0, scan = 0, sp = 0, s133 = 0, sens = 1, u1, u2, l1, l2, o1, o2;
  logic [3:0] cfg = 4'h0;
  logic [3:0] cfgs [5] = '{4'hF, 4'h9, 4'hA, 4'h0, 4'h5};
  slot_sense_pkg::slot_sense_type c1 = '0, c2 = '0, p1, p2;
  logic       en_o, hp_o, br_o, chg_o;
  logic [1:0] cnt_o, lc_o, s66_o, px_o, p133_o;
  logic [2:0] mode_o;
  int         n_fail = 0, checks_done = 0, seed = 32'h1e7b3208, m, i, pm = 0;
  initial forever #10 clk = ~clk;
  slot_model u_slot_model (.clk_i(clk), .sensor_i(sens), .card_i(c1), .pins_o(p1));
  slot_model u_slot_model_2 (.clk_i(clk), .sensor_i(sens), .card_i(c2), .pins_o(p2));
  hot_plug_slot_sense u_hot_plug_slot_sense (.MCLK_I(clk), .RST_N_I(rst_n), .HOTPLUG_SLOT_CONFIG_PINS_I(cfg),
    .SLOT1_SPEED66_CAPABLE_I(p1.speed66), .SLOT2_SPEED66_CAPABLE_I(p2.speed66),
    .SLOT1_RETENTION_LATCH_N_I(p1.latch_n), .SLOT2_RETENTION_LATCH_N_I(p2.latch_n),
    .SLOT1_PCIX_CAP_PRESENT_I(p1.pcix_cap), .SLOT1_PCIX_SPEED_CLASS_I(p1.pcix_class),
    .SLOT2_PCIX_CAP_PRESENT_I(p2.pcix_cap), .SLOT2_PCIX_SPEED_CLASS_I(p2.pcix_class),
    .SLOT2_CLOCK_REQ_I(req), .SCAN_START_I(scan), .SYSTEM_PCIX_OK_I(sp), .SYSTEM_133_OK_I(s133),
    .SLOT2_CLOCK_SWITCH_ENABLE_O(en_o), .HOTPLUG_ENABLED_O(hp_o), .SLOT_COUNT_O(cnt_o),
    .SLOT_LATCH_CLOSED_O(lc_o), .SLOT_SPEED66_O(s66_o), .SLOT_PCIX_O(px_o), .SLOT_PCIX133_O(p133_o),
    .LATCH_CHANGE_O(chg_o), .BUS_MODE_O(mode_o), .BUS_RESET_O(br_o));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report;
    if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(negedge clk);
    check(mode_o, 8'h00);
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      cfg  <= cfgs[i % 5];
      c1   <= 4'($random(seed));
      c2   <= 4'($random(seed));
      sens <= 1'($random(seed));
      req  <= 1'($random(seed));
      sp   <= 1'($random(seed));
      s133 <= 1'($random(seed));
      repeat (6) @(negedge clk);
      u1 = cfg == 4'hF || cfg == 4'h9 || cfg == 4'hA;
      u2 = cfg == 4'hA;
      l1 = !(c1.latch_n && sens);
      l2 = !(c2.latch_n && sens);
      check(hp_o, u1);
      check(cnt_o, u2 ? 8'h02 : {7'h00, u1});
      check(en_o, u2 & req);
      check(lc_o, {u2 & l2, u1 & l1});
      check(s66_o, {u2 & c2.speed66, u1 & c1.speed66});
      check(px_o, {u2 & c2.pcix_cap, u1 & c1.pcix_cap});
      check(p133_o, {u2 & c2.pcix_cap & c2.pcix_class, u1 & c1.pcix_cap & c1.pcix_class});
      check(chg_o, 8'h00);
      @(posedge clk);
      scan <= 1'b1;
      @(posedge clk);
      scan <= 1'b0;
      repeat (2) @(negedge clk);
      o1 = u1 & l1;
      o2 = u2 & l2;
      if (!(o1 | o2)) m = 0;
      else if (sp && (!o1 || c1.pcix_cap) && (!o2 || c2.pcix_cap))
        m = (s133 && (!o1 || c1.pcix_class) && (!o2 || c2.pcix_class)) ? 3 : 2;
      else m = ((!o1 || c1.speed66) && (!o2 || c2.speed66)) ? 1 : 0;
      check(mode_o, 8'(m));
      check(br_o, {7'h00, m != pm});
      pm = m;
    end
    final_report();
  end
endmodule : test_hot_plug_slot_sense
